// file: design/mrb_map.svh
// Register map, field positions, reset values and timing of the monitor register bank
`ifndef MRB_MAP_SVH
`define MRB_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MRB_CFG_ADDR 8'h00
`define MRB_STAT_ADDR 8'h01
`define MRB_MASK_ADDR 8'h03
`define MRB_RATE_ADDR 8'h07
`define MRB_DIS_ADDR 8'h08
`define MRB_ONESHOT_ADDR 8'h09
`define MRB_DEEP_ADDR 8'h0A
`define MRB_ADV_ADDR 8'h0B
`define MRB_BUSY_ADDR 8'h0C
`define MRB_RES_BASE 8'h20
`define MRB_RES_LAST 8'h27
`define MRB_LIM_BASE 8'h2A
`define MRB_LIM_LAST 8'h39
`define MRB_MAKER_ADDR 8'h3E
`define MRB_REV_ADDR 8'h3F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MRB_CFG_START 0
`define MRB_CFG_ALARM_EN 1
`define MRB_CFG_INT_CLR 3
`define MRB_CFG_INIT 7
`define MRB_ADV_EXTREF 0
`define MRB_ADV_MODE_HI 2
`define MRB_ADV_MODE_LO 1
`define MRB_BUSY_BIT 0
`define MRB_NOTRDY_BIT 1
`define MRB_CMP_HI 15
`define MRB_CMP_LO 8
`define MRB_TEMP_CHAN 3'h7

// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define MRB_CFG_RST 8'h08
`define MRB_STAT_RST 8'h00
`define MRB_MASK_RST 8'h00
`define MRB_RATE_RST 8'h00
`define MRB_DIS_RST 8'h00
`define MRB_DEEP_RST 8'h00
`define MRB_ADV_RST 8'h00
`define MRB_BUSY_RST 8'h02
`define MRB_RES_RST 16'h0000
`define MRB_LIM_RST 8'h00
`define MRB_CFG_WMASK 8'h8B
`define MRB_RATE_WMASK 8'h01
`define MRB_DEEP_WMASK 8'h01
`define MRB_ADV_WMASK 8'h07
`define MRB_VALID_M0 8'hFF
`define MRB_VALID_M1 8'hFF
`define MRB_VALID_M2 8'h8F
`define MRB_VALID_M3 8'hBF

// ----------------------------------------
// Timing
// ----------------------------------------
`define MRB_CLK_MHZ 200
`define MRB_TIMEOUT_MS 35
`define MRB_READY_CYCLES 6'h20

`endif

// file: design/mrb_pkg.sv
// Types shared by the monitor register bank modules
package mrb_pkg;
	typedef enum logic [3:0] {
		I_IDLE, I_ADDR, I_ADDR_ACK, I_REG, I_REG_ACK, I_WDAT, I_WDAT_ACK, I_RDAT, I_RACK
	} mrb_bus_state_type;

	typedef enum logic [1:0] {
		SQ_IDLE, SQ_PICK, SQ_WAIT
	} mrb_seq_state_type;
endpackage

// file: design/mrb_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module mrb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;
endmodule

// file: design/mrb_seq.sv
// Round-robin conversion sequencer
`timescale 1ns/1ps
module mrb_seq import mrb_pkg::*; (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	input wire logic oneshot_i,
	input wire logic [7:0] enable_i,
	// Converter handshake
	input wire logic conv_done_i,
	output logic conv_req_o,
	output logic [2:0] conv_chan_o,
	output logic busy_o
);
	mrb_seq_state_type state_ff;
	logic [2:0] chan_ff;
	logic single_ff;
	logic pend_ff;
	logic req_ff;

	// Set wins: a trigger landing as a pass starts queues another pass
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pend_ff <= 1'b0;
		end else if (oneshot_i) begin
			pend_ff <= 1'b1;
		end else if (state_ff == SQ_IDLE && !run_i) begin
			pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_ff <= SQ_IDLE;
			chan_ff <= 3'h0;
			single_ff <= 1'b0;
			req_ff <= 1'b0;
		end else begin
			req_ff <= 1'b0;
			case (state_ff)
				SQ_IDLE: begin
					if (run_i || pend_ff) begin
						chan_ff <= 3'h0;
						single_ff <= !run_i;
						state_ff <= SQ_PICK;
					end
				end
				SQ_PICK: begin
					if (!run_i && !single_ff) begin
						state_ff <= SQ_IDLE;
					end else if (enable_i[chan_ff]) begin
						req_ff <= 1'b1;
						state_ff <= SQ_WAIT;
					end else if (chan_ff == 3'h7) begin
						state_ff <= SQ_IDLE;
					end else begin
						chan_ff <= chan_ff + 3'h1;
					end
				end
				SQ_WAIT: begin
					if (conv_done_i) begin
						if (chan_ff == 3'h7) begin
							state_ff <= SQ_IDLE;
						end else begin
							chan_ff <= chan_ff + 3'h1;
							state_ff <= SQ_PICK;
						end
					end
				end
				default: state_ff <= SQ_IDLE;
			endcase
		end
	end

	assign conv_req_o = req_ff;
	assign conv_chan_o = chan_ff;
	assign busy_o = (state_ff != SQ_IDLE);
endmodule

// file: design/mrb_top.sv
// Monitor register bank with two-wire serial slave and alarm output
`timescale 1ns/1ps
`include "mrb_map.svh"

// Functional notes
// - Start bit runs monitoring; clear means shutdown
// - Alarm enable bit lets errors drive alarm
// - Interrupt-clear bit deasserts alarm, keeps status
// - Interrupt-clear bit halts the round-robin loop
// - Init bit restores every register default
// - Init bit clears itself after restoring
// - Configuration resets to 08h
// - Status read-only, reset zero, set on violation
// - Temperature bit set only above high limit
// - Mode 2 maps four pairs, bits 4-6 reserved
// - Mode 3 maps four inputs, two pairs
// - Mask bit blocks status from alarm
// - One-shot write launches one full pass
// - Disable bits skip channels; reset all enabled
// - Deep shutdown register enters deep shutdown only while start bit is clear
// - Advanced config picks reference and mode
// - Busy status reports busy, not ready; 02h
// - Eight read-only 16-bit result registers
// - Read-write 8-bit high/low limit registers
// - Read-only maker and revision codes
// - Mode field in advanced config bits 2:1
// - Bus line low 35 ms returns to idle
module mrb_top import mrb_pkg::*; #(
	parameter int TIMEOUT_CYCLES = `MRB_TIMEOUT_MS * `MRB_CLK_MHZ * 1000,
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] REVISION_CODE = 8'h3C // Arbitrary value
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [6:0] dev_addr_i,
	// Converter
	input wire logic conv_done_i,
	input wire logic [15:0] conv_data_i,
	output logic conv_req_o,
	output logic [2:0] conv_chan_o,
	// Device controls
	output logic alarm_n_o,
	output logic monitor_run_o,
	output logic deep_shutdown_o,
	output logic ext_ref_o,
	output logic [1:0] mode_o,
	output logic [1:0] conv_rate_o
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [8:0] pins_s;
	logic scl_s;
	logic sda_s;
	logic [6:0] addr_s;

	mrb_sync #(.W(9), .RST_VAL(9'h003)) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.d_i({dev_addr_i, scl_i, sda_i}),
		.q_o(pins_s)
	);

	assign addr_s = pins_s[8:2];
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic init_ff;
	logic soft_rst;
	logic [7:0] cfg_ff;
	logic [7:0] stat_ff;
	logic [7:0] nxt_stat;
	logic [7:0] mask_ff;
	logic [7:0] rate_ff;
	logic [7:0] dis_ff;
	logic [7:0] deep_ff;
	logic [7:0] adv_ff;
	logic [5:0] rdy_cnt_ff;
	logic alarm_n_ff;
	logic [15:0] res_ff [8];
	logic [7:0] lim_ff [16];
	logic wr_stb;
	logic rd_stb;
	logic [7:0] ptr_ff;
	logic [7:0] wdata;
	logic [7:0] lim_off;
	logic [7:0] valid_mask;
	logic [7:0] rd_byte;
	logic hi_lo_ff;
	logic seq_busy;
	logic run;
	logic not_ready;
	logic viol;
	logic [7:0] reading;
	logic [7:0] lim_hi;
	logic [7:0] lim_lo;
	logic is_temp;

	// Init pulse reloads every register; the bus engine is left alone
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			init_ff <= 1'b0;
		end else begin
			init_ff <= wr_stb && ptr_ff == `MRB_CFG_ADDR && wdata[`MRB_CFG_INIT];
		end
	end

	assign soft_rst = rst_i | init_ff;

	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			cfg_ff <= `MRB_CFG_RST;
			mask_ff <= `MRB_MASK_RST;
			rate_ff <= `MRB_RATE_RST;
			dis_ff <= `MRB_DIS_RST;
			deep_ff <= `MRB_DEEP_RST;
			adv_ff <= `MRB_ADV_RST;
		end else if (wr_stb) begin
			case (ptr_ff)
				`MRB_CFG_ADDR: cfg_ff <= wdata & `MRB_CFG_WMASK;
				`MRB_MASK_ADDR: mask_ff <= wdata;
				`MRB_RATE_ADDR: rate_ff <= wdata & `MRB_RATE_WMASK;
				`MRB_DIS_ADDR: dis_ff <= wdata;
				`MRB_DEEP_ADDR: deep_ff <= wdata & `MRB_DEEP_WMASK;
				`MRB_ADV_ADDR: adv_ff <= wdata & `MRB_ADV_WMASK;
				default: ;
			endcase
		end
	end

	assign lim_off = ptr_ff - `MRB_LIM_BASE;

	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			for (int i = 0; i < 16; i++) begin
				lim_ff[i] <= `MRB_LIM_RST;
			end
		end else if (wr_stb && ptr_ff >= `MRB_LIM_BASE && ptr_ff <= `MRB_LIM_LAST) begin
			lim_ff[lim_off[3:0]] <= wdata;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			for (int i = 0; i < 8; i++) begin
				res_ff[i] <= `MRB_RES_RST;
			end
		end else if (conv_done_i && seq_busy) begin
			res_ff[conv_chan_o] <= conv_data_i;
		end
	end

	// ----------------------------------------
	// Mode mapping and limit checks
	// ----------------------------------------
	always_comb begin
		case (adv_ff[`MRB_ADV_MODE_HI:`MRB_ADV_MODE_LO])
			2'h0: valid_mask = `MRB_VALID_M0;
			2'h1: valid_mask = `MRB_VALID_M1;
			2'h2: valid_mask = `MRB_VALID_M2;
			2'h3: valid_mask = `MRB_VALID_M3;
			default: valid_mask = `MRB_VALID_M0;
		endcase
	end

	// Channel 7 is the temperature sensor except in mode 1
	assign is_temp = conv_chan_o == `MRB_TEMP_CHAN && adv_ff[`MRB_ADV_MODE_HI:`MRB_ADV_MODE_LO] != 2'h1;
	assign reading = conv_data_i[`MRB_CMP_HI:`MRB_CMP_LO];
	assign lim_hi = lim_ff[{conv_chan_o, 1'b0}];
	assign lim_lo = lim_ff[{conv_chan_o, 1'b1}];
	assign viol = (reading > lim_hi) || (!is_temp && reading < lim_lo);

	// Clear on read; a violation in the same cycle wins
	always_comb begin
		nxt_stat = stat_ff;
		if (rd_stb && ptr_ff == `MRB_STAT_ADDR) begin
			nxt_stat = 8'h00;
		end
		if (conv_done_i && seq_busy && viol) begin
			nxt_stat[conv_chan_o] = 1'b1;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			stat_ff <= `MRB_STAT_RST;
		end else begin
			stat_ff <= nxt_stat & valid_mask;
		end
	end

	// ----------------------------------------
	// Alarm and sequencer control
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			alarm_n_ff <= 1'b1;
		end else begin
			alarm_n_ff <= !(|(stat_ff & ~mask_ff) && cfg_ff[`MRB_CFG_ALARM_EN]
				&& !cfg_ff[`MRB_CFG_INT_CLR]);
		end
	end

	assign run = cfg_ff[`MRB_CFG_START] && !cfg_ff[`MRB_CFG_INT_CLR] && !deep_ff[0];

	mrb_seq u_seq (
		.mclk_i(mclk_i),
		.rst_i(soft_rst || deep_shutdown_o),
		.run_i(run),
		.oneshot_i(wr_stb && ptr_ff == `MRB_ONESHOT_ADDR),
		.enable_i(valid_mask & ~dis_ff),
		.conv_done_i(conv_done_i),
		.conv_req_o(conv_req_o),
		.conv_chan_o(conv_chan_o),
		.busy_o(seq_busy)
	);

	always_ff @(posedge mclk_i) begin
		if (soft_rst) begin
			rdy_cnt_ff <= 6'h00;
		end else if (not_ready) begin
			rdy_cnt_ff <= rdy_cnt_ff + 6'h01;
		end
	end

	assign not_ready = rdy_cnt_ff != `MRB_READY_CYCLES;

	assign alarm_n_o = alarm_n_ff;
	assign monitor_run_o = run;
	assign deep_shutdown_o = deep_ff[0] && !cfg_ff[`MRB_CFG_START];
	assign ext_ref_o = adv_ff[`MRB_ADV_EXTREF];
	assign mode_o = adv_ff[`MRB_ADV_MODE_HI:`MRB_ADV_MODE_LO];
	assign conv_rate_o = rate_ff[1:0];

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_ff >= `MRB_RES_BASE && ptr_ff <= `MRB_RES_LAST) begin
			rd_byte = hi_lo_ff ? res_ff[ptr_ff[2:0]][7:0] : res_ff[ptr_ff[2:0]][15:8];
		end else if (ptr_ff >= `MRB_LIM_BASE && ptr_ff <= `MRB_LIM_LAST) begin
			rd_byte = lim_ff[lim_off[3:0]];
		end else begin
			case (ptr_ff)
				`MRB_CFG_ADDR: rd_byte = cfg_ff;
				`MRB_STAT_ADDR: rd_byte = stat_ff;
				`MRB_MASK_ADDR: rd_byte = mask_ff;
				`MRB_RATE_ADDR: rd_byte = rate_ff;
				`MRB_DIS_ADDR: rd_byte = dis_ff;
				`MRB_DEEP_ADDR: rd_byte = deep_ff;
				`MRB_ADV_ADDR: rd_byte = adv_ff;
				`MRB_BUSY_ADDR: rd_byte = {6'h00, not_ready, seq_busy};
				`MRB_MAKER_ADDR: rd_byte = MAKER_CODE;
				`MRB_REV_ADDR: rd_byte = REVISION_CODE;
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Serial bus slave
	// ----------------------------------------
	mrb_bus_state_type bus_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	logic [7:0] shift_ff;
	logic [3:0] bit_cnt_ff;
	logic rw_ff;
	logic sda_oe_ff;
	logic [22:0] tmo_cnt_ff;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic tmo_hit;
	logic byte_in;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_d_ff;
	assign scl_fall = !scl_s && scl_d_ff;
	assign start_det = scl_s && scl_d_ff && sda_d_ff && !sda_s;
	assign stop_det = scl_s && scl_d_ff && !sda_d_ff && sda_s;
	assign byte_in = scl_fall && bit_cnt_ff == 4'h8;

	// Either line stuck low restarts the slave and frees the data line
	always_ff @(posedge mclk_i) begin
		if (rst_i || (scl_s && sda_s)) begin
			tmo_cnt_ff <= 23'h000000;
		end else if (!tmo_hit) begin
			tmo_cnt_ff <= tmo_cnt_ff + 23'h000001;
		end
	end

	assign tmo_hit = tmo_cnt_ff == TIMEOUT_CYCLES[22:0];

	always_ff @(posedge mclk_i) begin
		if (rst_i || tmo_hit) begin
			bus_ff <= I_IDLE;
			sda_oe_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rw_ff <= 1'b0;
			ptr_ff <= 8'h00;
			hi_lo_ff <= 1'b0;
		end else if (start_det) begin
			bus_ff <= I_ADDR;
			sda_oe_ff <= 1'b0;
			bit_cnt_ff <= 4'h0;
			hi_lo_ff <= 1'b0;
		end else if (stop_det) begin
			bus_ff <= I_IDLE;
			sda_oe_ff <= 1'b0;
		end else begin
			if (scl_rise && (bus_ff == I_ADDR || bus_ff == I_REG || bus_ff == I_WDAT)) begin
				shift_ff <= {shift_ff[6:0], sda_s};
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
			end
			case (bus_ff)
				I_ADDR: begin
					if (byte_in) begin
						bit_cnt_ff <= 4'h0;
						rw_ff <= shift_ff[0];
						bus_ff <= (shift_ff[7:1] == addr_s) ? I_ADDR_ACK : I_IDLE;
						sda_oe_ff <= shift_ff[7:1] == addr_s;
					end
				end
				I_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_ff <= 4'h0;
						if (rw_ff) begin
							shift_ff <= rd_byte;
							sda_oe_ff <= !rd_byte[7];
							bus_ff <= I_RDAT;
						end else begin
							sda_oe_ff <= 1'b0;
							bus_ff <= I_REG;
						end
					end
				end
				I_REG: begin
					if (byte_in) begin
						bit_cnt_ff <= 4'h0;
						ptr_ff <= shift_ff;
						hi_lo_ff <= 1'b0;
						sda_oe_ff <= 1'b1;
						bus_ff <= I_REG_ACK;
					end
				end
				I_REG_ACK, I_WDAT_ACK: begin
					if (scl_fall) begin
						sda_oe_ff <= 1'b0;
						bus_ff <= I_WDAT;
					end
				end
				I_WDAT: begin
					if (byte_in) begin
						bit_cnt_ff <= 4'h0;
						sda_oe_ff <= 1'b1;
						bus_ff <= I_WDAT_ACK;
					end
				end
				I_RDAT: begin
					if (scl_fall) begin
						if (bit_cnt_ff == 4'h7) begin
							sda_oe_ff <= 1'b0;
							hi_lo_ff <= !hi_lo_ff;
							bus_ff <= I_RACK;
						end else begin
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
							shift_ff <= {shift_ff[6:0], 1'b0};
							sda_oe_ff <= !shift_ff[6];
						end
					end
				end
				I_RACK: begin
					if (scl_rise && sda_s) begin
						bus_ff <= I_IDLE;
					end else if (scl_fall) begin
						bit_cnt_ff <= 4'h0;
						shift_ff <= rd_byte;
						sda_oe_ff <= !rd_byte[7];
						bus_ff <= I_RDAT;
					end
				end
				default: bus_ff <= I_IDLE;
			endcase
		end
	end

	// Byte strobes toward the register file
	assign wr_stb = !rst_i && !tmo_hit && !start_det && !stop_det && bus_ff == I_WDAT && byte_in;
	assign wdata = shift_ff;
	assign rd_stb = !rst_i && !tmo_hit && !start_det && !stop_det && scl_fall
		&& ((bus_ff == I_ADDR_ACK && rw_ff) || (bus_ff == I_RACK));

	assign sda_o = 1'b0;
	assign sda_oe_o = sda_oe_ff;
endmodule

// file: tb/mrb_top_chk.sv
// Port-level assertions for the monitor register bank
`timescale 1ns/1ps
module mrb_top_chk #(
	parameter int TIMEOUT_CYCLES = 1000
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Serial bus
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_oe_o,
	// Converter
	input wire logic conv_done_i,
	input wire logic conv_req_o,
	input wire logic [2:0] conv_chan_o,
	// Device controls
	input wire logic alarm_n_o,
	input wire logic monitor_run_o,
	input wire logic deep_shutdown_o,
	input wire logic ext_ref_o,
	input wire logic [1:0] mode_o,
	input wire logic [1:0] conv_rate_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);

	// Saturating count of cycles with either bus line low
	int low_cnt_ff;
	always_ff @(posedge mclk_i) begin
		if (rst_i || (scl_i && sda_i))
			low_cnt_ff <= 0;
		else if (low_cnt_ff < TIMEOUT_CYCLES + 16)
			low_cnt_ff <= low_cnt_ff + 1;
	end

	sequence s_req_issued;
		conv_req_o ##1 1'b1;
	endsequence

	AST_RESET_STATE: assert property ($fell(rst_i) |-> alarm_n_o && !sda_oe_o && !monitor_run_o &&
		!deep_shutdown_o && !ext_ref_o && mode_o == 2'h0) else $error("outputs not at reset state");
	AST_DEEP_NO_RUN: assert property (deep_shutdown_o |-> !monitor_run_o ##1 !conv_req_o)
		else $error("monitoring while in deep shutdown");
	AST_ONE_REQ: assert property (s_req_issued |-> !conv_req_o until conv_done_i)
		else $error("second request before answer");
	AST_CHAN_HOLD: assert property (s_req_issued |-> $stable(conv_chan_o) until conv_done_i)
		else $error("channel moved during conversion");
	AST_MODE2_CHANNELS: assert property (conv_req_o && mode_o == 2'h2 |->
		conv_chan_o inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}) else $error("invalid channel in mode 2");
	AST_MODE3_CHANNELS: assert property (conv_req_o && mode_o == 2'h3 |-> conv_chan_o != 3'h6)
		else $error("invalid channel in mode 3");
	AST_CTRL_ON_WRITE: assert property ($changed({mode_o, ext_ref_o, conv_rate_o}) |-> !scl_i)
		else $error("control outputs changed outside a bus write");
	AST_SDA_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("data line moved while clock high");
	AST_TIMEOUT_RELEASE: assert property (low_cnt_ff == TIMEOUT_CYCLES + 8 |-> !sda_oe_o)
		else $error("data line still held after bus timeout");
	AST_ALARM_CAUSE: assert property ($fell(alarm_n_o) |-> !scl_i || $past(conv_done_i) ||
		$past(conv_done_i, 2) || $past(conv_done_i, 3)) else $error("alarm without a cause");
endmodule

// file: tb/mrb_bus_master.sv
// Behavioural two-wire bus master for the register bank
`timescale 1ns/1ps
module mrb_bus_master #(
	parameter int HALF = 8,
	parameter logic [6:0] DEV = 7'h2E
) (
	// Clock and bus
	input wire logic mclk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic start_cond();
		sda_o = 1'b1;
		tick(HALF / 2);
		scl_o = 1'b1;
		tick(HALF / 2);
		sda_o = 1'b0;
		tick(HALF / 2);
		scl_o = 1'b0;
		tick(HALF / 2);
	endtask
	task automatic stop_cond();
		sda_o = 1'b0;
		tick(HALF / 2);
		scl_o = 1'b1;
		tick(HALF / 2);
		sda_o = 1'b1;
		tick(HALF);
	endtask
	// Data moves mid low phase, well after the slave's synchronised clock fall
	task automatic bit_io(input logic b, output logic r);
		sda_o = b;
		tick(HALF / 2);
		scl_o = 1'b1;
		tick(HALF / 2);
		r = sda_i;
		tick(HALF / 2);
		scl_o = 1'b0;
		tick(HALF / 2);
	endtask
	task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= 0; i--)
			bit_io(w[i], r[i]);
		bit_io(last, nak);
	endtask
	task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data, output logic nak);
		logic [7:0] r;
		logic n0, n1, n2;
		start_cond();
		xfer({DEV, 1'b0}, 1'b1, r, n0);
		xfer(addr, 1'b1, r, n1);
		xfer(data, 1'b1, r, n2);
		stop_cond();
		nak = n0 | n1 | n2;
	endtask
	task automatic reg_rd(input logic [7:0] addr, input int nb, output logic [15:0] d, output logic nak);
		logic [7:0] r;
		logic n0, n1, n2, n3;
		start_cond();
		xfer({DEV, 1'b0}, 1'b1, r, n0);
		xfer(addr, 1'b1, r, n1);
		start_cond();
		xfer({DEV, 1'b1}, 1'b1, r, n2);
		d = 16'h0000;
		for (int i = 0; i < nb; i++) begin
			xfer(8'hFF, i == nb - 1, r, n3);
			d = {d[7:0], r};
		end
		stop_cond();
		nak = n0 | n1 | n2;
	endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the monitor register bank
`timescale 1ns/1ps
`include "mrb_map.svh"
`define CHK(got, exp) begin \
	tests_run++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
	end \
end
module testbench;
	localparam int TO = 1000;
	localparam logic [6:0] DEV = 7'h2E;
	logic mclk, rst, scl, mst_sda, sda_oe, sda_drv, conv_done, conv_req, alarm_n, run, deep, ext_ref, nak;
	logic [15:0] conv_data, rd;
	logic [15:0] conv_tab [8];
	logic [2:0] conv_chan;
	logic [1:0] mode, rate;
	logic [7:0] rb;
	int fails, tests_run, cyc, req_cnt, conv_wait;
	logic [7:0] wt_a [10] = '{8'h03, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h2A, 8'h39, 8'h01, 8'h0C, 8'h05};
	logic [7:0] wt_e [10] = '{8'hA5, 8'h01, 8'hA5, 8'h01, 8'h05, 8'hA5, 8'hA5, 8'h00, 8'h00, 8'h00};
	logic [7:0] md_adv [5] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h00};
	logic [7:0] md_dis [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81};
	logic [7:0] md_st [5] = '{8'hFF, 8'hFF, 8'h8F, 8'hBF, 8'h7E};
	int md_n [5] = '{8, 8, 5, 7, 6};
	// Open-drain data line with pull-up
	wire sda_line = mst_sda & ~(sda_oe & ~sda_drv);

	mrb_top #(.TIMEOUT_CYCLES(TO), .MAKER_CODE(8'hA5), .REVISION_CODE(8'h69)) i_dut ( // Codes arbitrary
		.mclk_i(mclk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv), .sda_oe_o(sda_oe),
		.dev_addr_i(DEV), .conv_done_i(conv_done), .conv_data_i(conv_data), .conv_req_o(conv_req),
		.conv_chan_o(conv_chan), .alarm_n_o(alarm_n), .monitor_run_o(run), .deep_shutdown_o(deep),
		.ext_ref_o(ext_ref), .mode_o(mode), .conv_rate_o(rate));
	mrb_bus_master #(.DEV(DEV)) i_mst (.mclk_i(mclk), .sda_i(sda_line), .scl_o(scl), .sda_o(mst_sda));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Converter stand-in: answers four cycles later, data scrambled when not valid
	always @(negedge mclk) begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data;
		if (conv_req) begin
			conv_wait <= 4;
			req_cnt <= req_cnt + 1;
		end else if (conv_wait == 1) begin
			conv_done <= 1'b1;
			conv_data <= conv_tab[conv_chan];
			conv_wait <= 0;
		end else if (conv_wait > 1)
			conv_wait <= conv_wait - 1;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_mst.reg_wr(a, d, nak);
		`CHK(nak, 1'b0)
	endtask
	task automatic rd_chk(input logic [7:0] a, input int nb, input logic [15:0] e);
		i_mst.reg_rd(a, nb, rd, nak);
		`CHK({nak, rd}, {1'b0, e})
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	initial begin
		rst = 1'b1;
		conv_done = 1'b0;
		conv_data = 16'h0000;
		conv_wait = 0;
		req_cnt = 0;
		for (int c = 0; c < 8; c++)
			conv_tab[c] = 16'h5000;
		wait_cyc(20);
		rst = 1'b0;
		wait_cyc(4);
		rd_chk(`MRB_CFG_ADDR, 1, 16'h0008);
		rd_chk(`MRB_BUSY_ADDR, 1, 16'h0000);
		rd_chk(`MRB_RES_BASE, 2, 16'h0000);
		rd_chk(`MRB_MAKER_ADDR, 1, 16'h00A5);
		rd_chk(`MRB_REV_ADDR, 1, 16'h0069);
		rd_chk(`MRB_ONESHOT_ADDR, 1, 16'h0000);
		for (int i = 0; i < 10; i++)
			rd_chk(wt_a[i], 1, 16'h0000);
		for (int i = 0; i < 10; i++)
			wr(wt_a[i], 8'hA5);
		for (int i = 0; i < 10; i++)
			rd_chk(wt_a[i], 1, {8'h00, wt_e[i]});
		`CHK({deep, ext_ref, mode, rate}, 6'h39)
		for (int i = 0; i < 5; i++)
			wr(wt_a[i], 8'h00);
		// Continuous monitoring against limits
		for (int c = 0; c < 8; c++) begin
			wr(`MRB_LIM_BASE + 8'(2 * c), 8'h80);
			wr(`MRB_LIM_BASE + 8'(2 * c + 1), 8'h20);
		end
		conv_tab[0] = 16'h9000;
		conv_tab[1] = 16'h1000;
		conv_tab[7] = 16'h1000;
		wr(`MRB_CFG_ADDR, 8'h03);
		wait_cyc(300);
		`CHK({run, alarm_n}, 2'b10)
		rd_chk(`MRB_STAT_ADDR, 1, 16'h0003);
		rd_chk(`MRB_RES_BASE, 2, 16'h9000);
		wr(`MRB_MASK_ADDR, 8'h03);
		wait_cyc(100);
		`CHK(alarm_n, 1'b1)
		wr(`MRB_MASK_ADDR, 8'h01);
		wait_cyc(100);
		`CHK(alarm_n, 1'b0)
		wr(`MRB_CFG_ADDR, 8'h01);
		wait_cyc(100);
		`CHK(alarm_n, 1'b1)
		wr(`MRB_CFG_ADDR, 8'h0B);
		wait_cyc(100);
		`CHK({run, alarm_n}, 2'b01)
		rd_chk(`MRB_STAT_ADDR, 1, 16'h0003);
		req_cnt = 0;
		wait_cyc(300);
		`CHK(req_cnt, 0)
		// Single passes in every mode, one with channels disabled
		for (int c = 0; c < 8; c++)
			conv_tab[c] = 16'h9000;
		for (int i = 0; i < 5; i++) begin
			wr(`MRB_ADV_ADDR, md_adv[i]);
			wr(`MRB_DIS_ADDR, md_dis[i]);
			req_cnt = 0;
			wr(`MRB_ONESHOT_ADDR, 8'h01);
			wait_cyc(200);
			`CHK(req_cnt, md_n[i])
			rd_chk(`MRB_STAT_ADDR, 1, {8'h00, md_st[i]});
		end
		wr(`MRB_CFG_ADDR, 8'h80);
		rd_chk(`MRB_CFG_ADDR, 1, 16'h0008);
		rd_chk(`MRB_DIS_ADDR, 1, 16'h0000);
		rd_chk(`MRB_LIM_BASE, 1, 16'h0000);
		rd_chk(`MRB_RES_BASE, 2, 16'h0000);
		// Clock held low while the slave drives a zero bit
		i_mst.start_cond();
		i_mst.xfer({DEV, 1'b1}, 1'b1, rb, nak);
		i_mst.tick(8);
		`CHK(sda_oe, 1'b1)
		i_mst.tick(TO + 50);
		`CHK(sda_oe, 1'b0)
		i_mst.stop_cond();
		rd_chk(`MRB_CFG_ADDR, 1, 16'h0008);
		final_report();
	end
endmodule

bind mrb_top mrb_top_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o),
	.conv_done_i(conv_done_i), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o), .alarm_n_o(alarm_n_o),
	.monitor_run_o(monitor_run_o), .deep_shutdown_o(deep_shutdown_o), .ext_ref_o(ext_ref_o),
	.mode_o(mode_o), .conv_rate_o(conv_rate_o));
